// ===== core/cpu_control_regs.sv
`timescale 1ns/100ps
// Notes on behaviour
// - 16-bit program counter advances by each fetched instruction's length.
// - Branches load the program counter from operand or register value.
// - After reset the counter loads from vector bytes at 0000 and 0001.
// - Status word is eight bits, seven of them flags (bit 2 unused), and resets to 02.
// - Status pushed on interrupt or push, restored by interrupt return and pop.
// - With enable flag clear only non-maskable requests are accepted.
// - With enable flag set acceptance also needs mask, priority, in-service.
// - Disable or acknowledge clears enable flag; enable instruction sets it.
// - Zero flag is one for a zero result, else zero.
// - Two bank bits pick one of four banks, set by select-bank.
// - Auxiliary carry follows carry out of or borrow into bit 3.
// - In-service flag clear blocks low-priority maskable vectored requests.
// - Carry takes add/subtract overflow, rotate shift-out, bit results.
// - Stack pointer must stay inside internal high-speed RAM.
// - Stack pointer decrements before each write, increments after reads.
// - General registers are four banks of eight bytes at FEE0-FEFF.
// - Registers are used singly or as four 16-bit pairs.
module cpu_control_regs #(
   parameter bit large_ram = 1'b1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire cpu_regs_pkg::cpu_cmd_type cmd,
   input wire cpu_regs_pkg::flag_cmd_type flags,
   input wire logic [7:0] vector_data,
   input wire logic nmi_request,
   input wire logic mask_request,
   input wire logic mask_masked,
   input wire logic mask_low_priority,
   output logic [15:0] program_counter,
   output logic [15:0] vector_addr,
   output logic vector_fetch,
   output logic [7:0] program_status_word,
   output logic [15:0] stack_pointer,
   output logic [15:0] pop_data,
   output logic accept_request,
   output logic busy
);
   import cpu_regs_pkg::*;

   typedef enum logic [1:0] {boot_low, boot_high, run} boot_type;

   logic [15:0] stack_ram [0:1023];
   logic [7:0] bank_ram [0:3][0:7];
   boot_type boot_reg;
   logic [7:0] vec_low_reg;
   logic stack_err_reg;
   logic [15:0] sp_next;
   logic bus_write;
   logic bus_read;
   logic [1:0] bank;
   logic [15:0] ram_base;
   logic accept_next;

   // One byte per word index; a push of a 16-bit value writes two bytes.
   function automatic logic [9:0] ram_idx(input logic [15:0] a);
      ram_idx = a[9:0];
   endfunction

   function automatic logic in_ram(input logic [15:0] a,
                                   input logic [15:0] base);
      in_ram = (a >= base) && (a <= ram_top);
   endfunction

   // Eight aligned words from the bank base; unaligned hits are refused.
   function automatic logic gpr_hit(input logic [11:0] a);
      gpr_hit = a >= off_gpr && a < off_gpr + 12'h020 && a[1:0] == 2'b00;
   endfunction

   function automatic logic [2:0] gpr_idx(input logic [11:0] a);
      gpr_idx = 3'((a - off_gpr) >> 2);
   endfunction

   assign ram_base = large_ram ? ram_base_large : ram_base_small;
   assign bank = {program_status_word[bank_high_bit],
                  program_status_word[bank_low_bit]};
   assign bus_write = psel && penable && pwrite;
   assign bus_read = psel && !penable && !pwrite;

   // Reset vector fetch sequence.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot_reg <= boot_low;
         vec_low_reg <= 8'h00;
         vector_addr <= 16'h0000;
         vector_fetch <= 1'b0;
         busy <= 1'b1;
      end else begin
         unique case (boot_reg)
            boot_low: begin
               vector_addr <= reset_vector_low_addr;
               vector_fetch <= 1'b1;
               boot_reg <= boot_high;
            end
            boot_high: begin
               vec_low_reg <= vector_data;
               vector_addr <= reset_vector_high_addr;
               boot_reg <= run;
            end
            run: begin
               vector_fetch <= 1'b0;
               busy <= 1'b0;
            end
         endcase
      end
   end

   // The memory answers the low byte a cycle after it is addressed.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         program_counter <= 16'h0000;
      end else if (boot_reg == run && busy) begin
         program_counter <= {vector_data, vec_low_reg};
      end else if (!busy) begin
         unique case (cmd.op)
            op_step: program_counter <= program_counter
               + {13'h0000, cmd.len};
            op_branch, op_call, op_interrupt:
               program_counter <= cmd.target;
            op_ret, op_int_return: program_counter <= pop_data;
            default: program_counter <= program_counter;
         endcase
      end
   end

   // Stack pointer moves: pre-decrement on push, post-increment on pop.
   always_comb begin
      sp_next = stack_pointer;
      unique case (cmd.op)
         op_push_status: sp_next = stack_pointer - 16'h0001;
         op_push_pair, op_call: sp_next = stack_pointer - 16'h0002;
         op_interrupt: sp_next = stack_pointer - 16'h0003;
         op_pop_status: sp_next = stack_pointer + 16'h0001;
         op_pop_pair, op_ret: sp_next = stack_pointer + 16'h0002;
         op_int_return: sp_next = stack_pointer + 16'h0003;
         default: sp_next = stack_pointer;
      endcase
   end

   // The stack pointer has no reset value; software must load it first.
   always_ff @(posedge pclk) begin
      if (bus_write && paddr == off_stack) begin
         stack_pointer <= pwdata[15:0];
      end else if (!busy && cmd.op != op_none) begin
         stack_pointer <= sp_next;
      end
   end

   // Stack memory writes; a push stores high byte at the higher address.
   always_ff @(posedge pclk) begin
      if (!busy) begin
         unique case (cmd.op)
            op_push_status:
               stack_ram[ram_idx(sp_next)] <= {8'h00, program_status_word};
            op_push_pair: begin
               stack_ram[ram_idx(sp_next + 16'h0001)] <=
                  {8'h00, cmd.pair_data[15:8]};
               stack_ram[ram_idx(sp_next)] <= {8'h00, cmd.pair_data[7:0]};
            end
            op_call: begin
               stack_ram[ram_idx(sp_next + 16'h0001)] <=
                  {8'h00, program_counter[15:8]};
               stack_ram[ram_idx(sp_next)] <= {8'h00, program_counter[7:0]};
            end
            op_interrupt: begin
               stack_ram[ram_idx(sp_next + 16'h0002)] <=
                  {8'h00, program_status_word};
               stack_ram[ram_idx(sp_next + 16'h0001)] <=
                  {8'h00, program_counter[15:8]};
               stack_ram[ram_idx(sp_next)] <= {8'h00, program_counter[7:0]};
            end
            default: begin
            end
         endcase
      end
   end

   assign pop_data = {stack_ram[ram_idx(stack_pointer + 16'h0001)][7:0],
                      stack_ram[ram_idx(stack_pointer)][7:0]};

   // Flags: enable first by priority of acknowledge over enable instruction.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         program_status_word <= status_reset;
      end else if (bus_write && paddr == off_status) begin
         program_status_word <= pwdata[7:0] & status_write_mask;
      end else if (!busy) begin
         if (cmd.op == op_pop_status) begin
            program_status_word <= stack_ram[ram_idx(stack_pointer)][7:0];
         end else if (cmd.op == op_int_return) begin
            program_status_word <=
               stack_ram[ram_idx(stack_pointer + 16'h0002)][7:0];
         end else begin
            if (flags.set_zero) begin
               program_status_word[zero_bit] <= flags.result == 8'h00;
            end
            if (flags.set_aux) begin
               program_status_word[aux_bit] <= flags.aux_out;
            end
            if (flags.set_carry) begin
               program_status_word[carry_bit] <= flags.carry_out;
            end
            if (flags.sel_bank) begin
               program_status_word[bank_high_bit] <= flags.bank[1];
               program_status_word[bank_low_bit] <= flags.bank[0];
            end
            if (flags.set_in_service) begin
               program_status_word[in_service_bit] <= flags.in_service;
            end
            if (flags.disable_int || cmd.op == op_interrupt) begin
               program_status_word[enable_bit] <= 1'b0;
            end else if (flags.enable_int) begin
               program_status_word[enable_bit] <= 1'b1;
            end
         end
      end
   end

   // Acceptance of a pending request.
   assign accept_next = nmi_request || (program_status_word[enable_bit]
      && mask_request && !mask_masked
      && (program_status_word[in_service_bit] || !mask_low_priority));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         accept_request <= 1'b0;
      end else begin
         accept_request <= !busy && accept_next;
      end
   end

   // Sticky flag for a stack access outside the internal RAM.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stack_err_reg <= 1'b0;
      end else if (!busy && cmd.op != op_none && cmd.op != op_step
                   && cmd.op != op_branch
                   && !in_ram(sp_next, ram_base)) begin
         stack_err_reg <= 1'b1;
      end else if (bus_write && paddr == off_stack_err) begin
         stack_err_reg <= 1'b0;
      end
   end

   // General register banks, one byte each, paired as 16-bit registers.
   always_ff @(posedge pclk) begin
      if (bus_write && gpr_hit(paddr)) begin
         bank_ram[bank][gpr_idx(paddr)] <= pwdata[7:0];
      end else if (!busy && cmd.op == op_pop_pair) begin
         bank_ram[bank][{cmd.pair_sel, 1'b1}] <= pop_data[15:8];
         bank_ram[bank][{cmd.pair_sel, 1'b0}] <= pop_data[7:0];
      end
   end

   // APB slave: zero wait states, read data captured in setup phase.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         if (bus_read) begin
            if (paddr == off_status) begin
               prdata <= {24'h000000, program_status_word};
            end else if (paddr == off_stack) begin
               prdata <= {16'h0000, stack_pointer};
            end else if (paddr == off_pc) begin
               prdata <= {16'h0000, program_counter};
            end else if (paddr == off_stack_err) begin
               prdata <= {31'h00000000, stack_err_reg};
            end else if (gpr_hit(paddr)) begin
               prdata <= {24'h000000, bank_ram[bank][gpr_idx(paddr)]};
            end else begin
               prdata <= 32'h00000000;
               pslverr <= 1'b1;
            end
         end
      end
   end

   property p_reset_vector;
      @(posedge pclk) disable iff (!presetn)
      (boot_reg == run && busy) |=>
         program_counter == {$past(vector_data), $past(vec_low_reg)};
   endproperty
   a_reset_vector: assert property (p_reset_vector)
      else $error("Counter not loaded from reset vector.");

   property p_step;
      @(posedge pclk) disable iff (!presetn)
      (!busy && cmd.op == op_step) |=>
         program_counter == $past(program_counter) + $past(cmd.len);
   endproperty
   a_step: assert property (p_step)
      else $error("Counter did not advance by length.");

   property p_branch;
      @(posedge pclk) disable iff (!presetn)
      (!busy && cmd.op == op_branch) |=> program_counter == $past(cmd.target);
   endproperty
   a_branch: assert property (p_branch)
      else $error("Branch target not loaded.");

   property p_ack_clears_enable;
      @(posedge pclk) disable iff (!presetn)
      (!busy && cmd.op == op_interrupt && !(psel && pwrite))
         |=> !program_status_word[enable_bit];
   endproperty
   a_ack_clears_enable: assert property (p_ack_clears_enable)
      else $error("Enable flag not cleared on acknowledge.");

   property p_no_mask_when_disabled;
      @(posedge pclk) disable iff (!presetn)
      (!busy && !program_status_word[enable_bit] && !nmi_request)
         |=> !accept_request;
   endproperty
   a_no_mask_when_disabled: assert property (p_no_mask_when_disabled)
      else $error("Maskable request taken while disabled.");

   property p_low_blocked;
      @(posedge pclk) disable iff (!presetn)
      (!nmi_request && mask_low_priority
         && !program_status_word[in_service_bit])
         |=> !accept_request;
   endproperty
   a_low_blocked: assert property (p_low_blocked)
      else $error("Low priority request taken while in service.");

   property p_push_predec;
      @(posedge pclk) disable iff (!presetn)
      (!busy && cmd.op == op_interrupt && !(psel && pwrite))
         |=> stack_pointer == $past(stack_pointer) - 16'h0003;
   endproperty
   a_push_predec: assert property (p_push_predec)
      else $error("Interrupt did not take three stack bytes.");

   property p_zero;
      @(posedge pclk) disable iff (!presetn)
      (!busy && flags.set_zero
         && !(cmd.op inside {op_pop_status, op_int_return})
         && !(psel && pwrite))
         |=> program_status_word[zero_bit] == ($past(flags.result) == 8'h00);
   endproperty
   a_zero: assert property (p_zero)
      else $error("Zero flag wrong.");

endmodule // cpu_control_regs

// ===== include/cpu_regs_pkg.sv
package cpu_regs_pkg;
   localparam logic [15:0] reset_vector_low_addr = 16'h0000;
   localparam logic [15:0] reset_vector_high_addr = 16'h0001;
   localparam logic [7:0] status_reset = 8'h02;
   localparam int enable_bit = 7;
   localparam int zero_bit = 6;
   localparam int bank_high_bit = 5;
   localparam int aux_bit = 4;
   localparam int bank_low_bit = 3;
   localparam int in_service_bit = 1;
   localparam int carry_bit = 0;
   localparam logic [7:0] status_write_mask = 8'hfb;
   localparam logic [15:0] ram_top = 16'hfeff;
   localparam logic [15:0] ram_base_small = 16'hfd00;
   localparam logic [15:0] ram_base_large = 16'hfb00;
   localparam logic [15:0] bank_area_base = 16'hfee0;
   localparam logic [11:0] off_status = 12'h000;
   localparam logic [11:0] off_stack = 12'h004;
   localparam logic [11:0] off_pc = 12'h008;
   localparam logic [11:0] off_gpr = 12'h010;
   localparam logic [11:0] off_stack_err = 12'h00c;

   typedef enum logic [3:0] {
      op_none, op_step, op_branch, op_push_status, op_push_pair,
      op_call, op_interrupt, op_pop_status, op_pop_pair, op_ret,
      op_int_return
   } cpu_op_type;

   typedef struct packed {
      cpu_op_type op;
      logic [2:0] len;
      logic [15:0] target;
      logic [15:0] pair_data;
      logic [1:0] pair_sel;
   } cpu_cmd_type;

   typedef struct packed {
      logic set_zero;
      logic set_aux;
      logic set_carry;
      logic [7:0] result;
      logic aux_out;
      logic carry_out;
      logic enable_int;
      logic disable_int;
      logic sel_bank;
      logic [1:0] bank;
      logic set_in_service;
      logic in_service;
   } flag_cmd_type;
endpackage

// ===== tb/vector_rom.sv
`timescale 1ns/100ps
module vector_rom #(
   parameter logic [15:0] boot_pc = 16'h0100
) (
   input wire logic pclk,
   input wire logic [15:0] vector_addr,
   input wire logic vector_fetch,
   output logic [7:0] vector_data
);
   logic [7:0] junk_reg = 8'h3c;
   logic hit;

   // Off the two vector bytes the bus shows a changing pattern, so a late
   // sample by the core cannot pass by luck.
   always_ff @(posedge pclk) begin
      junk_reg <= ~junk_reg ^ 8'h5a;
   end
   assign hit = vector_fetch && vector_addr[15:1] == 15'h0;
   assign vector_data = !hit ? junk_reg :
      (vector_addr[0] ? boot_pc[15:8] : boot_pc[7:0]);
endmodule // vector_rom

// ===== tb/test_cpu_control_regs.sv
`timescale 1ns/100ps
module test_cpu_control_regs;
   import cpu_regs_pkg::*;
   localparam logic [15:0] boot_pc = 16'h0100;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   cpu_cmd_type cmd;
   flag_cmd_type flags, f;
   logic [7:0] vector_data, program_status_word, r;
   logic nmi_request, mask_request, mask_masked, mask_low_priority;
   logic [15:0] program_counter, vector_addr, stack_pointer, pop_data;
   logic vector_fetch, accept_request, busy;
   logic [15:0] t, sp, pc;
   logic [2:0] len;
   logic [5:0] v;
   int fail_count = 0;
   int comparisons = 0;
   integer seed = 32'h3d449257;

   cpu_control_regs #(.large_ram(1'b1)) cpu_control_regs_i (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmd(cmd), .flags(flags),
      .vector_data(vector_data), .nmi_request(nmi_request),
      .mask_request(mask_request), .mask_masked(mask_masked),
      .mask_low_priority(mask_low_priority),
      .program_counter(program_counter), .vector_addr(vector_addr),
      .vector_fetch(vector_fetch), .program_status_word(program_status_word),
      .stack_pointer(stack_pointer), .pop_data(pop_data),
      .accept_request(accept_request), .busy(busy));
   vector_rom #(.boot_pc(boot_pc)) vector_rom_i (.pclk(pclk),
      .vector_addr(vector_addr), .vector_fetch(vector_fetch),
      .vector_data(vector_data));

   initial begin
      forever #5 pclk = ~pclk;
   end

   function automatic logic exp_accept(logic en, logic srv, logic nmi,
      logic req, logic msk, logic low);
      return nmi | (en & req & !msk & (srv | !low));
   endfunction

   function automatic logic [7:0] exp_bank(logic [7:0] p, logic [1:0] b);
      return (p & 8'hd7) | {2'b0, b[1], 1'b0, b[0], 3'b0};
   endfunction

   task automatic chk(input string nm, input logic [31:0] exp,
      input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         fail_count++;
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      if (n == 20) chk("pready", 1, pready);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Commands are one-cycle levels; results are looked at after the edge.
   task automatic run(input cpu_cmd_type c, input flag_cmd_type fl);
      @(posedge pclk);
      cmd <= c;
      flags <= fl;
      @(posedge pclk);
      cmd <= '0;
      flags <= '0;
      #1;
   endtask

   task wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      #200000;
      fail_count++;
      wrap_up;
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {nmi_request, mask_request, mask_masked, mask_low_priority} = '0;
      cmd = '0;
      flags = '0;
      repeat (16) @(posedge pclk);
      chk("psw in reset", 8'h02, program_status_word);
      presetn <= 1'b1;
      for (int i = 0; i < 20 && busy !== 1'b0; i++) @(posedge pclk);
      #1;
      chk("busy", 0, busy);
      chk("pc boot", boot_pc, program_counter);
      chk("psw boot", 8'h02, program_status_word);
      chk("fetch off", 0, vector_fetch);
      $display("test reset done");
      apb(1'b1, off_status, 32'hff);
      apb(1'b0, off_status, 32'h0);
      chk("psw read", 32'hfb, rd);
      apb(1'b1, off_status, 32'h02);
      sp = 16'hfc00 + (16'($random(seed)) & 16'h01fe);
      apb(1'b1, off_stack, {16'h0, sp});
      apb(1'b0, off_stack, 32'h0);
      chk("sp read", {16'h0, sp}, rd);
      apb(1'b0, off_pc, 32'h0);
      chk("pc read", {16'h0, boot_pc}, rd);
      apb(1'b0, 12'hffc, 32'h0);
      chk("unmapped err", 1, err);
      chk("unmapped data", 0, rd);
      $display("test registers done");
      pc = boot_pc;
      for (int i = 0; i < 6; i++) begin
         len = 3'd1 + 3'($random(seed) & 3);
         run(cpu_cmd_type'{op_step, len, 16'h0, 16'h0, 2'd0}, '0);
         pc += 16'(len);
         chk("pc step", pc, program_counter);
      end
      t = 16'($random(seed));
      run(cpu_cmd_type'{op_branch, 3'd0, t, 16'h0, 2'd0}, '0);
      chk("pc branch", t, program_counter);
      // The call ignores the length; the pushed return address is the current count.
      run(cpu_cmd_type'{op_call, 3'd0, 16'h2000, 16'h0, 2'd0}, '0);
      chk("call pc", 16'h2000, program_counter);
      chk("call sp", sp - 16'd2, stack_pointer);
      run(cpu_cmd_type'{op_ret, 3'd0, 16'h0, 16'h0, 2'd0}, '0);
      chk("ret pc", t, program_counter);
      chk("ret sp", sp, stack_pointer);
      pc = 16'($random(seed));
      run(cpu_cmd_type'{op_push_pair, 3'd0, 16'h0, pc, 2'd1}, '0);
      chk("push sp", sp - 16'd2, stack_pointer);
      chk("pair top", pc, pop_data);
      run(cpu_cmd_type'{op_pop_pair, 3'd0, 16'h0, 16'h0, 2'd1}, '0);
      chk("pop sp", sp, stack_pointer);
      apb(1'b0, off_gpr + 12'h008, 32'h0);
      chk("pair low", {24'h0, pc[7:0]}, rd);
      apb(1'b0, off_gpr + 12'h00c, 32'h0);
      chk("pair high", {24'h0, pc[15:8]}, rd);
      run(cpu_cmd_type'{op_push_status, 3'd0, 16'h0, 16'h0, 2'd0}, '0);
      chk("psw pushed", 8'h02, pop_data[7:0]);
      run(cpu_cmd_type'{op_pop_status, 3'd0, 16'h0, 16'h0, 2'd0}, '0);
      chk("pop status sp", sp, stack_pointer);
      f = '0;
      f.enable_int = 1'b1;
      run('0, f);
      chk("ei", 8'h82, program_status_word);
      run(cpu_cmd_type'{op_interrupt, 3'd0, 16'h3000, 16'h0, 2'd0}, '0);
      chk("ack psw", 8'h02, program_status_word);
      chk("ack sp", sp - 16'd3, stack_pointer);
      chk("ack pc", 16'h3000, program_counter);
      run(cpu_cmd_type'{op_int_return, 3'd0, 16'h0, 16'h0, 2'd0}, '0);
      chk("int return psw", 8'h82, program_status_word);
      chk("int return sp", sp, stack_pointer);
      chk("int return pc", t, program_counter);
      apb(1'b0, off_stack_err, 32'h0);
      chk("stack err clean", 0, rd);
      apb(1'b1, off_stack, 32'h0000fb02);
      run(cpu_cmd_type'{op_push_pair, 3'd0, 16'h0, 16'h0, 2'd0}, '0);
      apb(1'b0, off_stack_err, 32'h0);
      chk("stack err edge", 0, rd);
      apb(1'b1, off_stack, 32'h0000fb01);
      run(cpu_cmd_type'{op_push_pair, 3'd0, 16'h0, 16'h0, 2'd0}, '0);
      apb(1'b0, off_stack_err, 32'h0);
      chk("stack err set", 1, rd);
      apb(1'b1, off_stack_err, 32'h0);
      apb(1'b0, off_stack_err, 32'h0);
      chk("stack err clear", 0, rd);
      $display("test stack done");
      for (int i = 0; i < 5; i++) begin
         r = (i == 0) ? 8'h00 : 8'($random(seed));
         v = 6'($random(seed));
         f = '0;
         {f.set_zero, f.set_aux, f.set_carry} = 3'b111;
         {f.result, f.aux_out, f.carry_out} = {r, v[1:0]};
         run('0, f);
         chk("zero", r == 8'h00, program_status_word[zero_bit]);
         chk("aux", v[1], program_status_word[aux_bit]);
         chk("carry", v[0], program_status_word[carry_bit]);
      end
      for (int b = 0; b < 8; b++) begin
         f = '0;
         f.sel_bank = 1'b1;
         f.bank = 2'(b);
         r = program_status_word;
         run('0, f);
         chk("bank", exp_bank(r, 2'(b)), program_status_word);
         if (b < 4) apb(1'b1, off_gpr, 32'h10 + b);
         else apb(1'b0, off_gpr, 32'h0);
         if (b > 3) chk("gpr", 32'h10 + b - 4, rd);
      end
      $display("test flags done");
      for (int i = 0; i < 24; i++) begin
         v = (i == 0) ? 6'b001000 : (i == 1) ? 6'b011001 : 6'($random(seed));
         f = '0;
         {f.enable_int, f.disable_int, f.set_in_service, f.in_service} =
            {v[0], !v[0], 1'b1, v[1]};
         run('0, f);
         nmi_request <= v[2];
         mask_request <= v[3];
         mask_masked <= v[4];
         mask_low_priority <= v[5];
         repeat (2) @(posedge pclk);
         #1;
         chk("accept", exp_accept(v[0], v[1], v[2], v[3], v[4], v[5]),
            accept_request);
      end
      $display("test accept done");
      // A reset in mid-run must restart the vector fetch from scratch.
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("psw mid reset", 8'h02, program_status_word);
      chk("busy mid reset", 1, busy);
      presetn <= 1'b1;
      for (int i = 0; i < 20 && busy !== 1'b0; i++) @(posedge pclk);
      #1;
      chk("pc reboot", boot_pc, program_counter);
      chk("fetch off again", 0, vector_fetch);
      $display("test reset again done");
      wrap_up;
   end
endmodule // test_cpu_control_regs
